// File: core/led_sink_driver.v
// Control logic of an eight-channel constant-current LED sink driver with
// open-circuit error detection, plus its token FIFO.
// Assumes all pins are synchronous to sys_clk; serial_clk is sampled as data.
`timescale 1ns/100ps
`include "led_sink_map.vh"

// ----------------------------------------------------------------------
// Token FIFO
// ----------------------------------------------------------------------
module token_fifo #(
	parameter WIDTH = 2,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             sys_clk,
	input  wire             resetn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr_reg;
	reg [AW-1:0]    rptr_reg;
	reg [AW:0]      count_reg;
	reg             full_reg;
	reg             empty_reg;
	reg             ready_reg;
	wire            push;
	wire            pop;
	reg [AW:0]      count_next;

	// Push and pop only on honest handshakes; a push into a full FIFO is lost.
	// The ready flag is a flop of its own, so the top sees it straight from a register.
	assign push      = in_valid & ~full_reg;
	assign pop       = out_ready & ~empty_reg;
	assign in_ready  = ready_reg;
	assign out_valid = ~empty_reg;
	assign out_data  = mem[rptr_reg];

	// Occupancy after this cycle's transfers.
	always @* begin
		count_next = count_reg;
		if (push & ~pop)
			count_next = count_reg + 1'b1;
		else if (pop & ~push)
			count_next = count_reg - 1'b1;
	end

	// Storage is not reset; only pointers, count and flags are.
	always @(posedge sys_clk) begin
		if (push)
			mem[wptr_reg] <= in_data;
	end

	// Pointers, count and registered full, empty and ready flags.
	// The flags look at the next count, so they agree with the count itself
	// in every cycle and a simultaneous push and pop leaves them unchanged.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wptr_reg  <= {AW{1'b0}};
			rptr_reg  <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			full_reg  <= 1'b0;
			empty_reg <= 1'b1;
			ready_reg <= 1'b1;
		end else begin
			if (push)
				wptr_reg <= wptr_reg + 1'b1;
			if (pop)
				rptr_reg <= rptr_reg + 1'b1;
			count_reg <= count_next;
			full_reg  <= (count_next == DEPTH[AW:0]);
			empty_reg <= (count_next == {(AW+1){1'b0}});
			ready_reg <= (count_next != DEPTH[AW:0]);
		end
	end
endmodule

// ----------------------------------------------------------------------
// Sink driver top
// ----------------------------------------------------------------------
module led_sink_driver (
	input  wire       sys_clk,
	input  wire       resetn,
	input  wire       serial_clk,
	input  wire       serial_in,
	input  wire       latch_strobe,
	input  wire       output_blank_n,
	input  wire [7:0] open_sense,
	output wire       serial_out,
	output reg  [7:0] sink_channel,
	output wire       shift_ready,
	output reg        detect_mode
);
	// State: edge detector, shift path, latches, status and mode history.
	reg                   sclk_prev_reg;
	reg [`LSD_MSB:0]      shift_reg;
	reg [`LSD_MSB:0]      latch_reg;
	reg [`LSD_MSB:0]      error_reg;
	reg [`LSD_HIST_W-1:0] hist_reg;
	reg [`LSD_CNT_W-1:0]  settle_reg;

	// Combinational helpers and the token FIFO's read side.
	wire                  sclk_rise;
	wire                  sensing;
	wire [`LSD_HIST_W-1:0] hist_next;
	wire                  tok_valid;
	wire [`LSD_TOKEN_W-1:0] tok_data;
	wire                  drain_ready;
	wire                  load_req;

	// Serial clock edge detect; the pin is synchronous so one flop suffices.
	assign sclk_rise = serial_clk & ~sclk_prev_reg;
	assign hist_next = {hist_reg[`LSD_HIST_W-3:0], output_blank_n, latch_strobe};
	// Sinks lit in detection mode are under test, which freezes the shift path.
	assign sensing     = (detect_mode == `LSD_MODE_DETECT) & ~output_blank_n;
	assign drain_ready = ~sensing;
	// A serial edge while sensing asks for the status to be loaded.
	assign load_req    = sensing;
	assign serial_out  = shift_reg[`LSD_MSB];

	// Each serial edge becomes a token: a data bit or a status load request.
	// Tokens wait here while the lit sinks are under test, so that edges sent
	// during sensing are neither lost nor applied to a moving shift path.
	// Once eight tokens wait, shift_ready falls and further edges are dropped.
	token_fifo #(
		.WIDTH (`LSD_TOKEN_W),
		.DEPTH (`LSD_FIFO_DEPTH),
		.AW    (`LSD_FIFO_AW)
	) u_fifo (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_valid  (sclk_rise),
		.in_ready  (shift_ready),
		.in_data   ({load_req, serial_in}),
		.out_valid (tok_valid),
		.out_ready (drain_ready),
		.out_data  (tok_data)
	);

	// Edge history and mode sequence recognition.
	// Each serial edge appends the blank and strobe levels it sampled; the
	// oldest of the last five edges sits in the top bits. Entering needs the
	// blank high on all five edges with the strobe high on the third and fourth;
	// leaving has the same start but ends with both levels low.
	// The mode changes at the fifth sampling edge itself.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sclk_prev_reg <= 1'b0;
			hist_reg      <= {`LSD_HIST_W{1'b0}};
			detect_mode   <= `LSD_MODE_NORMAL;
		end else begin
			sclk_prev_reg <= serial_clk;
			if (sclk_rise) begin
				hist_reg <= hist_next;
				if (hist_next == `LSD_SEQ_ENTER)
					detect_mode <= `LSD_MODE_DETECT;
				else if (hist_next == `LSD_SEQ_EXIT)
					detect_mode <= `LSD_MODE_NORMAL;
			end
		end
	end

	// Open-circuit sensing once the lit sinks have settled.
	// The counter restarts whenever sensing stops, so a short unblanked spell
	// never yields a reading; after settling the status tracks every cycle.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			settle_reg <= {`LSD_CNT_W{1'b0}};
			error_reg  <= `LSD_ZERO8;
		end else if (!sensing) begin
			settle_reg <= {`LSD_CNT_W{1'b0}};
		end else if (settle_reg != `LSD_SETTLE_CYC) begin
			settle_reg <= settle_reg + 1'b1;
		end else begin
			error_reg <= latch_reg & open_sense;
		end
	end

	// Shift path: data bits shift in, load tokens copy the error status.
	// Only one token is taken per cycle, so each serial edge the FIFO accepts moves the path once
	// and the newest bit always enters at stage zero.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			shift_reg <= `LSD_ZERO8;
		end else if (tok_valid & drain_ready) begin
			if (tok_data[`LSD_TOK_LOAD])
				shift_reg <= error_reg;
			else
				shift_reg <= {shift_reg[`LSD_MSB-1:0], tok_data[`LSD_TOK_BIT]};
		end
	end

	// Output latches and blanking.
	// The strobe loads the latches and the blank clears the sinks at the edge that samples them; the
	// sinks are a register so that no input glitch reaches an output.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			latch_reg    <= `LSD_ZERO8;
			sink_channel <= `LSD_ZERO8;
		end else begin
			if (latch_strobe)
				latch_reg <= shift_reg;
			if (output_blank_n)
				sink_channel <= `LSD_ZERO8;
			else
				sink_channel <= latch_reg;
		end
	end
endmodule

// File: core/led_sink_map.vh
// Constants for the eight-channel LED sink driver control logic.
// Assumes a single 250 MHz system clock and synchronous pin inputs.
`ifndef LED_SINK_MAP_VH
`define LED_SINK_MAP_VH

// Channel count and shift path width.
`define LSD_CHANNELS     8
`define LSD_MSB          7
// FIFO geometry: token is {load_flag, data_bit}.
`define LSD_TOKEN_W      2
`define LSD_FIFO_DEPTH   8
`define LSD_FIFO_AW      3
`define LSD_TOK_LOAD     1
`define LSD_TOK_BIT      0
// Mode sequence: five edges of {output_blank_n, latch_strobe}, oldest first.
`define LSD_HIST_W       10
`define LSD_SEQ_ENTER    10'h2BE
`define LSD_SEQ_EXIT     10'h2BC
// Modes.
`define LSD_MODE_NORMAL  1'b0
`define LSD_MODE_DETECT  1'b1
// Sense settle time before an open-circuit reading is trusted:
// 500 cycles of the 4 ns clock, 2000 ns in all, at the counter's width.
`define LSD_SETTLE_CYC   10'h1F4
`define LSD_CNT_W        10
// Reset values.
`define LSD_ZERO8        8'h00

`endif

// File: verification/led_sink_driver_asserts.sv
// Port assertions for the LED sink driver.
// Assumes the port list of led_sink_driver and one clock.
`timescale 1ns/100ps
module led_sink_checker (
	input wire       sys_clk,
	input wire       resetn,
	input wire       serial_clk,
	input wire       serial_in,
	input wire       latch_strobe,
	input wire       output_blank_n,
	input wire [7:0] open_sense,
	input wire       serial_out,
	input wire [7:0] sink_channel,
	input wire       shift_ready,
	input wire       detect_mode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Timing relations between pins and outputs.
	AST_RESET: assert property (disable iff (1'b0) !resetn |->
		!serial_out && sink_channel == 8'h00 && shift_ready && !detect_mode)
		else $error("reset values wrong");
	AST_BLANK_OFF: assert property (output_blank_n [*3] |=> sink_channel == 8'h00)
		else $error("sinks lit while blanked");
	AST_LATCH_HOLD: assert property ((!latch_strobe && !output_blank_n) [*4]
		|=> $stable(sink_channel)) else $error("latch moved with strobe low");
	AST_FOLLOW: assert property ($changed(sink_channel) |-> $past(latch_strobe) ||
		$past(latch_strobe, 2) || $past(latch_strobe, 3) ||
		$past(output_blank_n) != $past(output_blank_n, 4)) else $error("sinks moved alone");
	AST_MODE_EDGE: assert property ($changed(detect_mode) |->
		$past(serial_clk) && !$past(serial_clk, 2)) else $error("mode moved off edge");
	AST_SOUT_TIME: assert property ($changed(serial_out) && !detect_mode |->
		$past(serial_clk, 2) && !$past(serial_clk, 3)) else $error("serial out late");
	AST_READY: assert property (!detect_mode [*8] |=> shift_ready)
		else $error("not ready in normal mode");
	AST_STALL: assert property ((detect_mode && !output_blank_n) [*3]
		|=> $stable(serial_out)) else $error("shifted while sensing");
endmodule
bind led_sink_driver led_sink_checker u_chk (.sys_clk, .resetn, .serial_clk, .serial_in,
	.latch_strobe, .output_blank_n, .open_sense, .serial_out, .sink_channel,
	.shift_ready, .detect_mode);

// File: verification/led_ctrl_model.sv
// Display controller model driving the serial pins.
// Assumes sys_clk at 250 MHz; serial clock kept at 25 MHz.
`timescale 1ns/100ps
module led_ctrl_model (
	input wire sys_clk,
	output reg serial_clk     = 1'b0,
	output reg serial_in      = 1'b0,
	output reg latch_strobe   = 1'b0,
	output reg output_blank_n = 1'b1
);
	// One serial edge, five cycles high and five low.
	task pulse(input d, input le, input bn);
		begin
			@(posedge sys_clk);
			serial_clk <= 1'b1;
			serial_in <= d;
			latch_strobe <= le;
			output_blank_n <= bn;
			repeat (5) @(posedge sys_clk);
			serial_clk <= 1'b0;
			serial_in <= ~d;
			repeat (4) @(posedge sys_clk);
		end
	endtask
	// Sets strobe and blank levels and waits n cycles.
	task hold(input le, input bn, input integer n);
		begin
			@(posedge sys_clk);
			latch_strobe <= le;
			output_blank_n <= bn;
			repeat (n - 1) @(posedge sys_clk);
		end
	endtask
endmodule

// File: verification/tb_led_sink_driver.sv
// Self-checking bench for the LED sink driver.
// Assumes led_ctrl_model drives the serial pins.
`timescale 1ns/100ps
module tb_led_sink_driver;
	reg        sys_clk    = 1'b0;
	reg        resetn     = 1'b1;
	reg  [7:0] open_sense = 8'h00;
	wire       serial_clk, serial_in, latch_strobe, output_blank_n;
	wire       serial_out, shift_ready, detect_mode;
	wire [7:0] sink_channel;
	integer    n_mismatch = 0;
	integer    n_compared = 0;
	integer    i;
	always #2 sys_clk = ~sys_clk;
	led_ctrl_model u_ctrl (.sys_clk(sys_clk), .serial_clk(serial_clk),
		.serial_in(serial_in), .latch_strobe(latch_strobe), .output_blank_n(output_blank_n));
	led_sink_driver u_dut (.sys_clk(sys_clk), .resetn(resetn), .serial_clk(serial_clk),
		.serial_in(serial_in), .latch_strobe(latch_strobe), .output_blank_n(output_blank_n),
		.open_sense(open_sense), .serial_out(serial_out), .sink_channel(sink_channel),
		.shift_ready(shift_ready), .detect_mode(detect_mode));
	task check(input [63:0] what, input [7:0] exp, input [7:0] got);
		begin
			#1 n_compared = n_compared + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task stop_test;
		begin
			$display("compared %0d mismatched %0d", n_compared, n_mismatch);
			if (n_mismatch == 0 && n_compared > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// Shifts a byte MSB first, checking serial_out after every edge.
	task shift8(input [7:0] b, input [7:0] prev);
		reg [15:0] w;
		begin
			w = {prev, b};
			for (i = 7; i >= 0; i = i - 1) begin
				u_ctrl.pulse(b[i], 1'b0, 1'b0);
				check("sout", {7'h00, w[i+7]}, {7'h00, serial_out});
			end
		end
	endtask
	task t_latch;
		begin
			shift8(8'hA5, 8'h00);
			check("hold", 8'h00, sink_channel);
			u_ctrl.hold(1'b1, 1'b0, 10);
			u_ctrl.hold(1'b0, 1'b0, 10);
			check("latch", 8'hA5, sink_channel);
			u_ctrl.hold(1'b0, 1'b1, 10);
			check("blank", 8'h00, sink_channel);
			u_ctrl.hold(1'b0, 1'b0, 10);
			check("unblank", 8'hA5, sink_channel);
			shift8(8'h3C, 8'hA5);
			check("hold2", 8'hA5, sink_channel);
			$display("test latch done");
		end
	endtask
	// Enter detection, fill the FIFO with load edges while sensing CF & 5A,
	// read 4A out, then exit; the sensing exit edge reloads the status once more.
	task t_detect;
		reg [7:0] err;
		begin
			err = 8'hCF & 8'h5A;
			@(posedge sys_clk);
			open_sense <= 8'h5A;
			u_ctrl.pulse(1'b1, 1'b0, 1'b1);
			u_ctrl.pulse(1'b1, 1'b0, 1'b1);
			u_ctrl.pulse(1'b1, 1'b1, 1'b1);
			u_ctrl.pulse(1'b1, 1'b1, 1'b1);
			u_ctrl.pulse(1'b1, 1'b0, 1'b1);
			check("enter", 8'h01, {7'h00, detect_mode});
			u_ctrl.hold(1'b0, 1'b0, 10);
			for (i = 0; i < 8; i = i + 1)
				u_ctrl.pulse(1'b0, 1'b0, 1'b0);
			check("full", 8'h00, {7'h00, shift_ready});
			u_ctrl.hold(1'b0, 1'b0, 520);
			u_ctrl.hold(1'b0, 1'b1, 10);
			check("err7", {7'h00, err[7]}, {7'h00, serial_out});
			for (i = 6; i >= 0; i = i - 1) begin
				u_ctrl.pulse(1'b0, 1'b0, 1'b1);
				check("errbit", {7'h00, err[i]}, {7'h00, serial_out});
			end
			u_ctrl.pulse(1'b0, 1'b0, 1'b1);
			u_ctrl.pulse(1'b0, 1'b0, 1'b1);
			u_ctrl.pulse(1'b0, 1'b1, 1'b1);
			u_ctrl.pulse(1'b0, 1'b1, 1'b1);
			u_ctrl.pulse(1'b0, 1'b0, 1'b0);
			check("exit", 8'h00, {7'h00, detect_mode});
			shift8(8'h96, err);
			$display("test detect done");
		end
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch = n_mismatch + 1;
		stop_test;
	end
	initial begin
		#1 resetn = 1'b0;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		check("ready", 8'h01, {7'h00, shift_ready});
		t_latch;
		t_detect;
		stop_test;
	end
endmodule
